// File: src/tpt_pkg.sv
// Constants shared by the transmit trigger block
`default_nettype none
package tpt_pkg;
   localparam int OBJ_N = 2;
   localparam int ADDR_W = 12;
   // Register map, byte addresses; second object sits one stride above the first
   localparam logic [11:0] OBJ_STRIDE = 12'h020;
   localparam logic [11:0] OFS_COUNT = 12'h000;
   localparam logic [11:0] OFS_IDENT = 12'h004;
   localparam logic [11:0] OFS_TYPE = 12'h008;
   localparam logic [11:0] OFS_HOLD = 12'h00c;
   localparam logic [11:0] OFS_PERIOD = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h040;
   // Field layout of the identifier word
   localparam int ID_W = 11;
   localparam int RTR_BIT = 30;
   localparam int DIS_BIT = 31;
   localparam logic [10:0] ID_BASE = 11'h180;
   // Reset values
   localparam logic [7:0] ENTRY_COUNT = 8'h05;
   localparam logic [10:0] ID_RST = 11'h000;
   localparam logic [7:0] TYPE_RST = 8'hff;
   localparam logic [15:0] HOLD_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0064;
   // Trigger type codes
   localparam logic [7:0] TYPE_ACYC = 8'h00;
   localparam logic [7:0] TYPE_SYNC_MAX = 8'hf0;
   localparam logic [7:0] TYPE_RES_LO = 8'hf1;
   localparam logic [7:0] TYPE_RES_HI = 8'hfd;
   localparam logic [7:0] TYPE_APP = 8'hfe;
   localparam logic [7:0] TYPE_PROF = 8'hff;
   // Holdoff is kept in 100 us units, whole milliseconds only
   localparam logic [15:0] HOLD_STEP = 16'h000a;
   localparam logic [15:0] HOLD_MAX = 16'hfffa;
   // Timing
   localparam int CLK_KHZ = 40000;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = CLK_KHZ * TICK_US / 1000;
   localparam int TICKS_PER_MS = 1000 / TICK_US;
   typedef enum logic [1:0] {CAUSE_NONE, CAUSE_SYNC, CAUSE_APP, CAUSE_TIMER} tpt_cause_t;
endpackage
`default_nettype wire

// File: src/tpt_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tpt_fifo #(
   parameter int WIDTH = 44,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;
   // Extra pointer bit tells full from empty
   assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (do_wr) wr_q <= wr_q + 1'b1;
         if (do_rd) rd_q <= rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (do_wr) mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

// File: src/tpt_tpdo_trigger.sv
// Transmit object parameters and send trigger logic with APB register access
// Contract
// - Identifier word low 11 bits hold the frame ID, default base plus node number.
// - Identifier bits 11 to 29 always read zero.
// - Bit 30 reads zero and ignores writes.
// - Bit 31 set disables the object; no frames are sent then.
// - Trigger type resets to 255.
// - Holdoff sets the least gap between sends; zero means none.
// - Holdoff writes round up to whole milliseconds.
// - Period timer in ms, default 100; zero stops timer sends.
// - Types 1 to 240 send once every N sync messages.
// - Type 0 sends on sync only if the value changed since last sync.
// - Type 254 sends on an application event.
// - Type 254 with nonzero timer also sends on value change.
// - Type 254 sends are held off by the holdoff time.
// - Type 255 with nonzero timer sends at each period end.
// - Types 254 and 255 may use a 1 to 65535 ms period timer.
// - Entry count reads the number of sub-entries and is read-only.
// - After reset, timer expiry sends the measured value.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tpt_tpdo_trigger #(
   parameter int TICK_CYC = tpt_pkg::TICK_CYC,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tpt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [6:0] node_id,
   input wire logic sync_pulse,
   input wire logic [tpt_pkg::OBJ_N-1:0] app_event,
   input wire logic [tpt_pkg::OBJ_N-1:0] value_changed,
   input wire logic [tpt_pkg::OBJ_N*32-1:0] sample_value,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [tpt_pkg::OBJ_N-1:0] tx_obj,
   output logic [10:0] tx_id,
   output logic [31:0] tx_data
);
   localparam int N = tpt_pkg::OBJ_N;
   localparam int FW = N + 11 + 32;

   ////////////////////////////////////////////////////////////////////////////
   // Time base: 100 us tick and 1 ms tick
   logic [12:0] pre_q;
   logic [3:0] ms_div_q;
   wire tick_w = (pre_q == 13'(TICK_CYC - 1));
   wire ms_tick_w = tick_w && (ms_div_q == 4'(tpt_pkg::TICKS_PER_MS - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_q <= '0;
         ms_div_q <= '0;
      end else begin
         pre_q <= tick_w ? 13'h0000 : pre_q + 13'h0001;
         if (tick_w) ms_div_q <= (ms_div_q == 4'(tpt_pkg::TICKS_PER_MS - 1)) ? 4'h0 : ms_div_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, read data captured in the setup cycle
   wire setup_w = psel && !penable;
   wire wr_en_w = psel && penable && pwrite;
   wire in_obj_w = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
   wire obj_w = paddr[5];
   wire [4:0] sub_w = paddr[4:0];
   wire sel_count_w = in_obj_w && (sub_w == tpt_pkg::OFS_COUNT[4:0]);
   wire sel_ident_w = in_obj_w && (sub_w == tpt_pkg::OFS_IDENT[4:0]);
   wire sel_type_w = in_obj_w && (sub_w == tpt_pkg::OFS_TYPE[4:0]);
   wire sel_hold_w = in_obj_w && (sub_w == tpt_pkg::OFS_HOLD[4:0]);
   wire sel_per_w = in_obj_w && (sub_w == tpt_pkg::OFS_PERIOD[4:0]);
   wire sel_stat_w = (paddr == tpt_pkg::OFS_STATUS);
   wire mapped_w = sel_count_w || sel_ident_w || sel_type_w || sel_hold_w || sel_per_w || sel_stat_w;

   logic [31:0] ident_rd [N];
   logic [10:0] id_q [N];
   logic [N-1:0] dis_q;
   logic [N-1:0] dflt_q;
   logic [7:0] type_q [N];
   logic [15:0] hold_q [N];
   logic [15:0] per_q [N];
   logic [15:0] hcnt_q [N];
   logic [15:0] mcnt_q [N];
   logic [7:0] scnt_q [N];
   logic [N-1:0] chg_q;
   logic [N-1:0] pend_q;
   logic [N-1:0] fire_w;
   logic [N-1:0] rdy_w;
   logic [N-1:0] push_w;
   logic [N-1:0] hact_w;
   logic [N-1:0] sync_fire_w;
   logic [31:0] prdata_q;
   tpt_pkg::tpt_cause_t cause_q;
   logic fifo_in_ready;

   // Status: [1:0] holdoff active, [3:2] pending, [4] queue full, [6:5] last cause
   wire [31:0] status_w = {25'h0, cause_q, !fifo_in_ready, pend_q, hact_w};
   wire [31:0] sel_rd_w = sel_count_w ? {24'h000000, tpt_pkg::ENTRY_COUNT} :
                          sel_ident_w ? ident_rd[obj_w] :
                          sel_type_w ? {24'h000000, type_q[obj_w]} :
                          sel_hold_w ? {16'h0000, hold_q[obj_w]} :
                          sel_per_w ? {16'h0000, per_q[obj_w]} :
                          sel_stat_w ? status_w : 32'h00000000;
   wire [31:0] mask_w = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [31:0] merged_w = (sel_rd_w & ~mask_w) | (pwdata & mask_w);

   // Round up to whole ms; clamp so the rounding cannot leave 16 bits
   wire [16:0] hold_up_w = {1'b0, merged_w[15:0]} + {1'b0, tpt_pkg::HOLD_STEP - 16'h0001};
   wire [16:0] hold_rnd_w = (hold_up_w / {1'b0, tpt_pkg::HOLD_STEP}) * {1'b0, tpt_pkg::HOLD_STEP};
   wire [15:0] hold_wr_w = (merged_w[15:0] > tpt_pkg::HOLD_MAX) ? tpt_pkg::HOLD_MAX : hold_rnd_w[15:0];
   wire type_ok_w = !((merged_w[7:0] >= tpt_pkg::TYPE_RES_LO) && (merged_w[7:0] <= tpt_pkg::TYPE_RES_HI));

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped_w;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) prdata_q <= 32'h00000000;
      else if (setup_w && !pwrite) prdata_q <= sel_rd_w;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-object registers and triggers
   for (genvar i = 0; i < N; i++) begin : g_obj
      wire wr_obj_w = wr_en_w && (obj_w == 1'(i));
      wire [7:0] typ_w = type_q[i];
      wire is_cyc_w = (typ_w != tpt_pkg::TYPE_ACYC) && (typ_w <= tpt_pkg::TYPE_SYNC_MAX);
      wire is_app_w = (typ_w == tpt_pkg::TYPE_APP);
      wire is_prof_w = (typ_w == tpt_pkg::TYPE_PROF);
      wire per_on_w = (per_q[i] != 16'h0000);
      wire per_end_w = ms_tick_w && per_on_w && ({1'b0, mcnt_q[i]} + 17'h00001 >= {1'b0, per_q[i]});
      wire sync_hit_w = (scnt_q[i] + 8'h01 == typ_w);
      wire [10:0] id_eff_w = dflt_q[i] ? tpt_pkg::ID_BASE + {4'h0, node_id} : id_q[i];
      // Reserved ID bits and the remote-request bit are constant zero
      assign ident_rd[i] = {dis_q[i], 1'b0, 19'h00000, id_eff_w};
      assign sync_fire_w[i] = sync_pulse && (((typ_w == tpt_pkg::TYPE_ACYC) && (chg_q[i] || value_changed[i]))
                              || (is_cyc_w && sync_hit_w));
      assign fire_w[i] = !dis_q[i] && (sync_fire_w[i]
                         || (is_app_w && app_event[i])
                         || (is_app_w && per_on_w && value_changed[i])
                         || ((is_app_w || is_prof_w) && per_end_w));
      assign hact_w[i] = (hcnt_q[i] != 16'h0000);
      assign rdy_w[i] = pend_q[i] && !hact_w[i] && !dis_q[i];

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            id_q[i] <= tpt_pkg::ID_RST;
            dis_q[i] <= 1'b0;
            dflt_q[i] <= 1'b1;
            type_q[i] <= tpt_pkg::TYPE_RST;
            hold_q[i] <= tpt_pkg::HOLD_RST;
            per_q[i] <= tpt_pkg::PERIOD_RST;
         end else if (wr_obj_w) begin
            if (sel_ident_w) begin
               id_q[i] <= merged_w[tpt_pkg::ID_W-1:0];
               dis_q[i] <= merged_w[tpt_pkg::DIS_BIT];
               dflt_q[i] <= 1'b0;
            end
            if (sel_type_w && type_ok_w) type_q[i] <= merged_w[7:0];
            if (sel_hold_w) hold_q[i] <= hold_wr_w;
            if (sel_per_w) per_q[i] <= merged_w[15:0];
         end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            scnt_q[i] <= 8'h00;
            chg_q[i] <= 1'b0;
            mcnt_q[i] <= 16'h0000;
         end else begin
            // A change in the same cycle as the sync is kept for the next one
            chg_q[i] <= value_changed[i] || (chg_q[i] && !sync_pulse);
            if (wr_obj_w && sel_type_w) scnt_q[i] <= 8'h00;
            else if (sync_pulse && is_cyc_w) scnt_q[i] <= sync_hit_w ? 8'h00 : scnt_q[i] + 8'h01;
            if (!per_on_w) mcnt_q[i] <= 16'h0000;
            else if (ms_tick_w) mcnt_q[i] <= per_end_w ? 16'h0000 : mcnt_q[i] + 16'h0001;
         end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            pend_q[i] <= 1'b0;
            hcnt_q[i] <= 16'h0000;
         end else begin
            // New trigger wins over the clear by a push; disable drops it
            pend_q[i] <= !dis_q[i] && (fire_w[i] || (pend_q[i] && !push_w[i]));
            if (push_w[i]) hcnt_q[i] <= hold_q[i];
            else if (tick_w && hact_w[i]) hcnt_q[i] <= hcnt_q[i] - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fixed priority to the lower object; one frame queued per cycle
   wire [N-1:0] grant_w = rdy_w & ~(rdy_w - 2'b01);
   assign push_w = grant_w & {N{fifo_in_ready}};
   wire gsel_w = grant_w[1];
   wire [FW-1:0] fin_w = {grant_w, id_eff_sel(gsel_w), sample_value[gsel_w*32 +: 32]};
   wire [FW-1:0] fout_w;

   function automatic logic [10:0] id_eff_sel(input logic s);
      id_eff_sel = ident_rd[s][10:0];
   endfunction

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) cause_q <= tpt_pkg::CAUSE_NONE;
      else if (|fire_w) begin
         cause_q <= (|sync_fire_w) ? tpt_pkg::CAUSE_SYNC :
                    ((|(app_event & ~dis_q)) ? tpt_pkg::CAUSE_APP : tpt_pkg::CAUSE_TIMER);
      end
   end

   // Holding back here is what lets a slow transmitter fill the queue
   tpt_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(|rdy_w),
      .in_ready(fifo_in_ready),
      .in_data(fin_w),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(fout_w)
   );
   assign tx_obj = fout_w[FW-1 -: N];
   assign tx_id = fout_w[42:32];
   assign tx_data = fout_w[31:0];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ident_rd_zero: assert property (setup_w && !pwrite && sel_ident_w |=> prdata_q[30:11] == 20'h00000)
      else $error("identifier word reserved bits not zero");
   a_disabled_no_push: assert property (dis_q[0] |-> !push_w[0] ##1 !pend_q[0])
      else $error("disabled object queued a frame");
   a_type_after_reset: assert property ($past(sys_rst) |-> type_q[0] == 8'hff && type_q[1] == 8'hff)
      else $error("trigger type not 255 after reset");
   a_holdoff_blocks: assert property (hcnt_q[0] != 16'h0000 |-> !push_w[0])
      else $error("frame sent inside holdoff");
   a_hold_rounded: assert property (wr_en_w && sel_hold_w |=> (hold_q[$past(obj_w)] % 16'h000a) == 16'h0000)
      else $error("holdoff not whole milliseconds");
   a_period_zero_quiet: assert property (per_q[0] == 16'h0000 && is_prof_w0() |-> !fire_w[0])
      else $error("timer send with zero period");
   a_sync_every_one: assert property (sync_pulse && type_q[0] == 8'h01 && !dis_q[0] |=> pend_q[0])
      else $error("type 1 did not trigger on sync");
   a_acyc_needs_chg: assert property (type_q[0] == 8'h00 && sync_pulse && !chg_q[0] && !value_changed[0]
      |-> !fire_w[0])
      else $error("type 0 sent without value change");
   a_reserved_kept: assert property (wr_en_w && sel_type_w && pwdata[7:0] == 8'hf5 && pstrb[0]
      |=> type_q[0] == $past(type_q[0]) && type_q[1] == $past(type_q[1]))
      else $error("reserved trigger type accepted");

   function automatic logic is_prof_w0();
      is_prof_w0 = (type_q[0] == tpt_pkg::TYPE_PROF);
   endfunction

   c_timer_send: cover property (is_prof_w0() && fire_w[0] ##[1:4] push_w[0]);
   c_app_send: cover property (type_q[1] == tpt_pkg::TYPE_APP && app_event[1] ##[1:4] push_w[1]);
   c_fifo_full: cover property (tx_valid && !tx_ready && !fifo_in_ready);
   c_sync_send: cover property (sync_pulse && type_q[0] == 8'h03 && fire_w[0]);
endmodule
`default_nettype wire

// File: verif/tpt_bus_master_model.sv
// Behavioural network-side consumer of the transmit frame stream
`timescale 1ns/1ps
`default_nettype none
module tpt_bus_master_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic slow,
   output logic tx_ready
);
   logic phase_q;
   ////////////////////////////////////////////////////////////////
   // Slow mode accepts only every other cycle so the FIFO backs up
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end
   assign tx_ready = !stall && (!slow || phase_q);
endmodule
`default_nettype wire

// File: verif/tpt_tpdo_trigger_tb_top.sv
// Self-checking bench for the transmit trigger block
`timescale 1ns/1ps
`default_nettype none
module tpt_tpdo_trigger_tb_top;
   localparam int TCYC = 4;
   localparam int MS = TCYC * tpt_pkg::TICKS_PER_MS;
   localparam logic [11:0] S = tpt_pkg::OBJ_STRIDE;
   localparam logic [11:0] C0 = tpt_pkg::OFS_COUNT;
   localparam logic [11:0] I0 = tpt_pkg::OFS_IDENT;
   localparam logic [11:0] T0 = tpt_pkg::OFS_TYPE;
   localparam logic [11:0] H0 = tpt_pkg::OFS_HOLD;
   localparam logic [11:0] P0 = tpt_pkg::OFS_PERIOD;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, sync_pulse, tx_valid, tx_ready, stall, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, tx_data, rnd;
   logic [3:0] pstrb;
   logic [6:0] node_id;
   logic [1:0] app_event, value_changed, tx_obj;
   logic [63:0] sample_value;
   logic [10:0] tx_id;
   logic [32:0] rdq[$];
   logic [44:0] txq[$];
   int num_errors, cmp_count, frames, cyc, f0;

   tpt_tpdo_trigger #(.TICK_CYC(TCYC), .FIFO_DEPTH(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .node_id(node_id), .sync_pulse(sync_pulse), .app_event(app_event),
      .value_changed(value_changed), .sample_value(sample_value), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_obj(tx_obj), .tx_id(tx_id), .tx_data(tx_data));
   tpt_bus_master_model i_master (.clk(clk), .sys_rst(sys_rst), .stall(stall), .slow(slow), .tx_ready(tx_ready));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [44:0] got, input logic [44:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Setup, then access held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
      rdq.push_back({err, exp});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input logic [1:0] ap, input logic [1:0] vc, input logic sy);
      @(posedge clk);
      app_event <= ap;
      value_changed <= vc;
      sync_pulse <= sy;
      @(posedge clk);
      app_event <= 2'b00;
      value_changed <= 2'b00;
      sync_pulse <= 1'b0;
   endtask
   task automatic syncs(input int n);
      repeat (n) begin
         pulse(2'b00, 2'b00, 1'b1);
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic drain;
      while (txq.size() != 0) @(posedge clk);
      repeat (10) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   // Result watcher: each answer takes the oldest note off its queue
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         summarize();
      end
      if (psel && penable && pready && !pwrite) begin
         chk({12'h0, pslverr, prdata}, {12'h0, rdq.pop_front()}, "read data");
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         frames++;
         if (txq.size() == 0) begin
            num_errors++;
            $display("wrong value at %0t: unexpected frame id %h", $time, tx_id);
         end else begin
            chk({tx_obj, tx_id, tx_data}, txq.pop_front(), "frame");
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, psel, penable, pwrite, sync_pulse, stall, slow} = 7'h40;
      {paddr, pwdata, app_event, value_changed, sample_value} = '0;
      pstrb = 4'hf;
      rnd = 32'ha90a10f6;
      node_id = rnd[6:0];
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(C0 + S, 32'h5);
      rd(I0, {21'h0, tpt_pkg::ID_BASE + {4'h0, node_id}});
      rd(T0 + S, 32'hff);
      rd(H0 + S, 32'h0);
      rd(P0 + S, 32'h64);
      wr(I0, 32'hffff_fd23);
      rd(I0, 32'h8000_0523);
      wr(I0 + S, 32'h8000_02a5);
      wr(C0, 32'h77);
      rd(C0, 32'h5);
      for (int t = 241; t <= 253; t++) begin
         wr(T0, t);
         rd(T0, 32'hff);
      end
      wr(H0, 32'h0f);
      rd(H0, 32'h14);
      wr(H0, 32'h0);
      rd(12'h080, 32'h0, 1'b1);
      // Every third sync sends; the disabled object stays silent
      rnd = lfsr(rnd);
      sample_value <= {rnd, ~rnd};
      wr(T0, 32'h3);
      wr(I0, 32'h123);
      repeat (2) txq.push_back({2'b01, 11'h123, ~rnd});
      syncs(6);
      drain();
      // Consumer stalls: four frames fill the FIFO, the fifth waits pending
      wr(T0, 32'h1);
      stall <= 1'b1;
      syncs(5);
      rd(tpt_pkg::OFS_STATUS, 32'h34);
      repeat (5) txq.push_back({2'b01, 11'h123, ~rnd});
      stall <= 1'b0;
      slow <= 1'b1;
      drain();
      wr(I0, 32'h8000_0123);
      wr(T0 + S, 32'h0);
      wr(I0 + S, 32'h2a5);
      syncs(1);
      pulse(2'b00, 2'b10, 1'b0);
      txq.push_back({2'b10, 11'h2a5, rnd});
      syncs(1);
      drain();
      wr(T0 + S, 32'hfe);
      wr(P0 + S, 32'h0);
      wr(H0 + S, 32'h0a);
      f0 = frames;
      repeat (2) txq.push_back({2'b10, 11'h2a5, rnd});
      pulse(2'b10, 2'b00, 1'b0);
      repeat (5) @(posedge clk);
      pulse(2'b10, 2'b00, 1'b0);
      repeat (20) @(posedge clk);
      chk(45'(frames), 45'(f0 + 1), "held frames");
      repeat (MS) @(posedge clk);
      chk(45'(frames), 45'(f0 + 2), "released frames");
      wr(P0 + S, 32'h3e8);
      txq.push_back({2'b10, 11'h2a5, rnd});
      pulse(2'b00, 2'b10, 1'b0);
      drain();
      wr(I0 + S, 32'h8000_02a5);
      wr(P0, 32'h2);
      wr(T0, 32'hff);
      wr(I0, 32'h123);
      repeat (2) txq.push_back({2'b01, 11'h123, ~rnd});
      drain();
      // Zero period must stop timer sends; any frame now is unexpected
      wr(P0, 32'h0);
      repeat (4 * MS) @(posedge clk);
      summarize();
   end
endmodule
`default_nettype wire
